// >>> msgbuf_map.vh
// constants for the message buffer manager
`ifndef MSGBUF_MAP_VH
`define MSGBUF_MAP_VH
// protocol state encodings
`define ST_DEFAULT_CFG 3'h0
`define ST_CONFIG      3'h1
`define ST_READY       3'h2
`define ST_WAKEUP      3'h3
`define ST_STARTUP     3'h4
`define ST_NORM_ACT    3'h5
`define ST_NORM_PAS    3'h6
`define ST_HALT        3'h7
// write-protect modes
`define WP_NONE        2'h0
`define WP_BOTH        2'h1
`define WP_CLASS2      2'h2
// buffer and field sizes
`define NBUF           4
`define BIDX_W         2
`define PL_W           16
`define PL_DEPTH       4
`define PL_AW          2
`define SLOT_W         11
`define LEN_W          7
`define HCRC_W         11
`define STAT_W         8
// class 1 layout: type, channel(2), slot, cycle mask
`define C1_W           22
`define C1_TYPE        21
`define C1_CHB         20
`define C1_CHA         19
`define C1_SLOT_LO     8
`define C1_CYC_LO      0
`define CYC_W          8
// class 2 layout: len, preamble, hcrc, mode
`define C2_W           20
`define C2_MODE        19
`define C2_PRE         18
`define C2_HCRC_LO     7
`define C2_LEN_LO      0
// reset values and receive fifo depth
`define C1_RST         22'h000000
`define C2_RST         20'h00000
`define FIFO_DEPTH     4
`endif

// >>> rx_fifo.v
// small valid/ready fifo for received payload words
`timescale 1ns/1ns
module rx_fifo #(
  parameter W  = 18,
  parameter D  = 4,
  parameter AW = 2
) (
  input  wire         mclk,
  input  wire         nrst,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0]  mem [0:D-1];   // storage
  reg [AW-1:0] wp_r;          // write pointer
  reg [AW-1:0] rp_r;          // read pointer
  reg [AW:0]   cnt_r;         // fill level
  wire         push = in_valid && in_ready;
  wire         pop  = out_valid && out_ready;
  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem[rp_r];
  // pointers and level
  always @(posedge mclk) begin
    if (!nrst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
  // data store, no reset needed
  always @(posedge mclk) begin
    if (push) mem[wp_r] <= in_data;
  end
endmodule // rx_fifo

// >>> msgbuf_mgr.v
// non-queued message buffer store between host and protocol engine
// Overview of operation
// RULE_01 - static slot: transmit always beats receive
// RULE_02 - dynamic slot: transmit wins only if valid
// RULE_03 - after normal to halt/ready, freeze contents
// RULE_04 - never-updated status reads as no traffic
// RULE_05 - class1 holds type, channel, slot, cycles
// RULE_06 - tx adds length, preamble, crc, mode
// RULE_07 - length counts two-byte payload words
// RULE_08 - two configuration classes, class1 and class2
// RULE_09 - config readable always, writable in config
// RULE_10 - no config writes in default configuration
// RULE_11 - write protect: none, both, class2 only
// RULE_12 - write protect applies to all buffers
// RULE_13 - refuse config change while buffer busy
// RULE_14 - status, channel and updated indicator kept
// RULE_15 - config write clears updated and valid
// RULE_16 - ready to startup clears updated, rx valid
// RULE_17 - entering ready from run clears tx valid
// RULE_18 - host writes tx payload only, reads all
// RULE_19 - deliver config, status, payload consistently
// RULE_20 - host sets tx valid to request sending
// RULE_21 - rx valid set once payload stored
// RULE_22 - buffer disabled while configuring, else enabled
// RULE_23 - locked buffer: no update, no candidacy
`timescale 1ns/1ns
`include "msgbuf_map.vh"
module msgbuf_mgr (
  input  wire                   mclk,
  input  wire                   nrst,
  // protocol state and write-protect setting
  input  wire [2:0]             proto_state,
  input  wire [1:0]             wp_mode_in,
  input  wire                   wp_mode_load,
  // host configuration access
  input  wire [`BIDX_W-1:0]     host_buf,
  input  wire                   host_c1_wr,
  input  wire [`C1_W-1:0]       host_c1_wdata,
  input  wire                   host_c2_wr,
  input  wire [`C2_W-1:0]       host_c2_wdata,
  input  wire                   host_cfg_done,
  output reg                    host_cfg_refused,
  output reg  [`C1_W-1:0]       host_c1_rdata,
  output reg  [`C2_W-1:0]       host_c2_rdata,
  output reg  [`STAT_W-1:0]     host_stat_rdata,
  output reg                    host_stat_ch_b,
  output reg                    host_stat_upd,
  output reg                    host_valid_rdata,
  output reg                    host_enabled,
  // host payload access
  input  wire [`PL_AW-1:0]      host_pl_addr,
  input  wire                   host_pl_wr,
  input  wire [`PL_W-1:0]       host_pl_wdata,
  input  wire                   host_valid_set,
  input  wire                   host_valid_clr,
  input  wire                   host_lock,
  output reg  [`PL_W-1:0]       host_pl_rdata,
  // slot lookup from the protocol engine
  input  wire                   slot_start,
  input  wire [`SLOT_W-1:0]     slot_id,
  input  wire [`CYC_W-1:0]      cycle_num,
  input  wire                   slot_ch_b,
  input  wire                   slot_dynamic,
  output reg                    tx_sel,
  output reg                    rx_sel,
  output reg  [`BIDX_W-1:0]     act_buf,
  output reg                    tx_data_available_flag,
  output reg  [`LEN_W-1:0]      tx_len,
  output reg                    tx_preamble,
  output reg  [`HCRC_W-1:0]     tx_hcrc,
  // transmit payload fetch and completion
  input  wire [`PL_AW-1:0]      tx_pl_addr,
  output reg  [`PL_W-1:0]       tx_pl_data,
  input  wire                   tx_done,
  input  wire [`STAT_W-1:0]     tx_status,
  // received words and slot status from the protocol engine
  input  wire [`PL_W-1:0]       rx_word,
  input  wire                   rx_word_valid,
  output wire                   rx_word_ready,
  input  wire                   rx_done,
  input  wire [`STAT_W-1:0]     rx_status
);
  localparam NB = `NBUF;
  reg  [`C1_W-1:0]   c1_r    [0:NB-1];            // class 1 config
  reg  [`C2_W-1:0]   c2_r    [0:NB-1];            // class 2 config
  reg  [`STAT_W-1:0] stat_r  [0:NB-1];            // slot status
  reg  [NB-1:0]      stch_r;                      // status channel
  reg  [NB-1:0]      upd_r;                       // status updated
  reg  [NB-1:0]      val_r;                       // payload valid
  reg  [NB-1:0]      en_r;                        // configuration complete
  reg  [NB-1:0]      lock_r;                      // host lock
  reg  [`PL_W-1:0]   pl_r    [0:NB*`PL_DEPTH-1];  // payload store
  reg  [1:0]         wp_r;                        // write-protect mode
  reg  [2:0]         st_prev_r;                   // last protocol state
  reg                busy_r;                      // slot owns act_buf
  reg  [`PL_AW-1:0]  rx_wa_r;                     // receive word index
  wire [`PL_W+1:0]   fo_data;
  wire               fo_valid;
  wire               fo_ready;                    // held off while the host writes payload
  // buffer path is frozen outside the running states
  wire running = (proto_state == `ST_STARTUP) || (proto_state == `ST_NORM_ACT)
              || (proto_state == `ST_NORM_PAS);
  // state transition events
  wire ev_ready_start = (st_prev_r == `ST_READY) && (proto_state == `ST_STARTUP);
  wire ev_run_ready   = (proto_state == `ST_READY) && (st_prev_r == `ST_STARTUP ||
                        st_prev_r == `ST_NORM_ACT || st_prev_r == `ST_NORM_PAS);
  // write permission per class
  wire in_cfg  = (proto_state == `ST_CONFIG);
  wire in_dflt = (proto_state == `ST_DEFAULT_CFG);
  wire c1_ok = !in_dflt && (in_cfg || wp_r == `WP_BOTH);            // see RULE_09 see RULE_10
  wire c2_ok = !in_dflt && (in_cfg || wp_r == `WP_BOTH || wp_r == `WP_CLASS2); // see RULE_11
  wire in_use = busy_r && (act_buf == host_buf);                    // see RULE_13
  wire c1_take = host_c1_wr && c1_ok && !in_use;
  wire c2_take = host_c2_wr && c2_ok && !in_use;
  // one write port on the store: a host payload write holds the fifo for a cycle
  wire host_pl_take = host_pl_wr && c1_r[host_buf][`C1_TYPE] && !in_use;  // see RULE_18
  assign fo_ready = !host_pl_take;
  wire rx_acc  = fo_valid && fo_ready && !fo_data[`PL_W+1];  // word entry, not end marker
  wire rx_end  = fo_valid && fo_ready && fo_data[`PL_W+1];
  // rx words pass through the fifo; the end marker carries the frame status
  rx_fifo #(.W(`PL_W+2), .D(`FIFO_DEPTH), .AW(2)) u_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_data   ({rx_done, 1'b0, rx_done ? {{(`PL_W-`STAT_W){1'b0}}, rx_status} : rx_word}),
    .in_valid  (rx_word_valid || rx_done),
    .in_ready  (rx_word_ready),
    .out_data  (fo_data),
    .out_valid (fo_valid),
    .out_ready (fo_ready)
  );
  // candidate search, lowest index wins for determinism (for tx, the lowest valid buffer if any is valid)
  integer i;
  reg tx_f, rx_f, txv_f;
  reg [`BIDX_W-1:0] tx_i, rx_i;
  reg match;
  always @* begin
    tx_f = 1'b0; rx_f = 1'b0; txv_f = 1'b0;
    tx_i = {`BIDX_W{1'b0}}; rx_i = {`BIDX_W{1'b0}}; match = 1'b0;
    for (i = NB-1; i >= 0; i = i - 1) begin
      // enabled and unlocked only; see RULE_22 see RULE_23
      match = en_r[i] && !lock_r[i] && (c1_r[i][`C1_SLOT_LO +: `SLOT_W] == slot_id)
           && (slot_ch_b ? c1_r[i][`C1_CHB] : c1_r[i][`C1_CHA])
           && c1_r[i][`C1_CYC_LO + cycle_num[2:0]];
      if (match && c1_r[i][`C1_TYPE]) begin
        // valid buffers preferred over non-valid ones
        if (val_r[i] || !txv_f) begin
          tx_i = i[`BIDX_W-1:0];
        end
        tx_f  = 1'b1;
        txv_f = txv_f | val_r[i];
      end else if (match) begin
        rx_i = i[`BIDX_W-1:0];
        rx_f = 1'b1;
      end
    end
  end
  // dynamic segment needs a valid payload for tx to take the slot
  wire tx_wins = tx_f && (!slot_dynamic || txv_f);  // see RULE_01 see RULE_02
  // slot decision latched for the whole slot
  always @(posedge mclk) begin
    if (!nrst) begin
      tx_sel <= 1'b0;
      rx_sel <= 1'b0;
      act_buf <= {`BIDX_W{1'b0}};
      busy_r <= 1'b0;
      tx_data_available_flag <= 1'b0;
      tx_len <= {`LEN_W{1'b0}};
      tx_preamble <= 1'b0;
      tx_hcrc <= {`HCRC_W{1'b0}};
    end else if (slot_start && running) begin
      tx_sel <= tx_wins;
      rx_sel <= !tx_wins && rx_f;                   // see RULE_01
      act_buf <= tx_wins ? tx_i : rx_i;
      busy_r <= tx_wins || rx_f;
      // class 2 snapshot keeps header and payload consistent; see RULE_19
      tx_data_available_flag <= tx_wins && txv_f;
      tx_len <= c2_r[tx_i][`C2_LEN_LO +: `LEN_W];   // see RULE_07
      tx_preamble <= c2_r[tx_i][`C2_PRE];
      tx_hcrc <= c2_r[tx_i][`C2_HCRC_LO +: `HCRC_W];
    end else if (tx_done || rx_end || !running) begin
      busy_r <= 1'b0;
      tx_sel <= 1'b0;
      rx_sel <= 1'b0;
      tx_data_available_flag <= 1'b0;
    end
  end
  // per-buffer config, status and flags
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : gb
      wire sel  = (host_buf == g);
      wire mine = busy_r && (act_buf == g) && running && !lock_r[g];  // see RULE_03 see RULE_23
      wire is_tx = c1_r[g][`C1_TYPE];
      always @(posedge mclk) begin
        if (!nrst) begin
          c1_r[g] <= `C1_RST;
          c2_r[g] <= `C2_RST;
          stat_r[g] <= {`STAT_W{1'b0}};   // zero means no traffic; see RULE_04
          stch_r[g] <= 1'b0;
          upd_r[g] <= 1'b0;
          val_r[g] <= 1'b0;
          en_r[g] <= 1'b0;
          lock_r[g] <= 1'b0;
        end else begin
          if (sel && c1_take) c1_r[g] <= host_c1_wdata;  // see RULE_05 see RULE_08 see RULE_12
          if (sel && c2_take) c2_r[g] <= host_c2_wdata;  // see RULE_06
          if (sel) lock_r[g] <= host_lock;
          // disabled until host signals completion; see RULE_22
          if (sel && (c1_take || c2_take)) en_r[g] <= 1'b0;
          else if (sel && host_cfg_done) en_r[g] <= 1'b1;
          // status update from the engine; see RULE_14
          if (mine && (tx_done || rx_end)) begin
            stat_r[g] <= tx_done ? tx_status : fo_data[`STAT_W-1:0];
            stch_r[g] <= slot_ch_b;
          end
          // updated indicator: set beats clear
          if (mine && (tx_done || rx_end)) upd_r[g] <= 1'b1;
          else if ((sel && (c1_take || c2_take)) || ev_ready_start) upd_r[g] <= 1'b0;  // see RULE_15 see RULE_16
          // payload valid flag
          if (mine && rx_end && !is_tx) val_r[g] <= 1'b1;                  // see RULE_21
          else if (sel && (c1_take || c2_take)) val_r[g] <= 1'b0;          // see RULE_15
          else if (ev_ready_start && !is_tx) val_r[g] <= 1'b0;             // see RULE_16
          else if (ev_run_ready && is_tx) val_r[g] <= 1'b0;                // see RULE_17
          else if (mine && tx_done && !c2_r[g][`C2_MODE]) val_r[g] <= 1'b0; // single shot
          else if (sel && is_tx && host_valid_set) val_r[g] <= 1'b1;       // see RULE_18 see RULE_20
          else if (sel && is_tx && host_valid_clr) val_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  // payload store: host writes tx only, rx words land in the active buffer
  always @(posedge mclk) begin
    if (host_pl_take)                                                    // see RULE_18
      pl_r[{host_buf, host_pl_addr}] <= host_pl_wdata;
    else if (rx_acc && rx_sel && running && !lock_r[act_buf])
      pl_r[{act_buf, rx_wa_r}] <= fo_data[`PL_W-1:0];
  end
  // receive word index
  always @(posedge mclk) begin
    if (!nrst) rx_wa_r <= {`PL_AW{1'b0}};
    else if (slot_start || rx_end) rx_wa_r <= {`PL_AW{1'b0}};
    else if (rx_acc) rx_wa_r <= rx_wa_r + 1'b1;
  end
  // registered read ports, protect setting and state history
  always @(posedge mclk) begin
    if (!nrst) begin
      wp_r <= `WP_NONE;
      st_prev_r <= `ST_DEFAULT_CFG;
      host_cfg_refused <= 1'b0;
      host_c1_rdata <= {`C1_W{1'b0}};
      host_c2_rdata <= {`C2_W{1'b0}};
      host_stat_rdata <= {`STAT_W{1'b0}};
      host_stat_ch_b <= 1'b0;
      host_stat_upd <= 1'b0;
      host_valid_rdata <= 1'b0;
      host_enabled <= 1'b0;
      host_pl_rdata <= {`PL_W{1'b0}};
      tx_pl_data <= {`PL_W{1'b0}};
    end else begin
      if (wp_mode_load && in_cfg) wp_r <= wp_mode_in;                   // see RULE_11
      st_prev_r <= proto_state;
      host_cfg_refused <= (host_c1_wr && !c1_take) || (host_c2_wr && !c2_take); // see RULE_13
      host_c1_rdata <= c1_r[host_buf];                                  // see RULE_09
      host_c2_rdata <= c2_r[host_buf];
      host_stat_rdata <= stat_r[host_buf];                              // see RULE_03
      host_stat_ch_b <= stch_r[host_buf];
      host_stat_upd <= upd_r[host_buf];
      host_valid_rdata <= val_r[host_buf];
      host_enabled <= en_r[host_buf];
      host_pl_rdata <= pl_r[{host_buf, host_pl_addr}];
      tx_pl_data <= pl_r[{act_buf, tx_pl_addr}];                        // see RULE_19
    end
  end
endmodule // msgbuf_mgr

// >>> msgbuf_mgr_props.sv
// assertion checker bound to the message buffer manager ports
`timescale 1ns/1ns
`include "msgbuf_map.vh"
module msgbuf_mgr_chk (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [2:0] proto_state,
  input wire logic [1:0] wp_mode_in,
  input wire logic       wp_mode_load,
  input wire logic [1:0] host_buf,
  input wire logic       host_c1_wr,
  input wire logic       host_c2_wr,
  input wire logic       host_cfg_done,
  input wire logic       host_cfg_refused,
  input wire logic [7:0] host_stat_rdata,
  input wire logic       host_stat_upd,
  input wire logic       host_enabled,
  input wire logic       tx_sel,
  input wire logic       rx_sel
);
  reg  [1:0] wp_r;                                    // mirror of the write-protect mode
  wire       run_st = proto_state > `ST_CONFIG;        // outside both configuration states
  wire       cfg_wr = host_c1_wr || host_c2_wr;       // any configuration write
  // a load outside config must not move the mirror, the design ignores it too
  always @(posedge mclk) begin
    if (!nrst)
      wp_r <= `WP_NONE;
    else if (wp_mode_load && proto_state == `ST_CONFIG)
      wp_r <= wp_mode_in;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_default_refuse: assert property (
    host_c1_wr && proto_state == `ST_DEFAULT_CFG |=> host_cfg_refused)
    else $error("default configuration write was taken");
  a_wp_class1: assert property (
    host_c1_wr && run_st && wp_r != `WP_BOTH |=> host_cfg_refused)
    else $error("protected class 1 write was taken");
  a_refuse_cause: assert property (host_cfg_refused |-> $past(cfg_wr))
    else $error("refusal without a write");
  a_tx_beats_rx: assert property (tx_sel |-> !rx_sel)
    else $error("receive chosen beside transmit");
  a_write_clears: assert property (
    host_c1_wr && proto_state == `ST_CONFIG ##1 $stable(host_buf) |=> !host_stat_upd)
    else $error("updated flag survives a rewrite");
  a_startup_clear: assert property (
    proto_state == `ST_STARTUP && $past(proto_state) == `ST_READY ##1 $stable(host_buf)
    |=> !host_stat_upd)
    else $error("updated flag survives startup");
  a_halt_freeze: assert property (
    proto_state == `ST_HALT && $past(proto_state) == `ST_HALT && $stable(host_buf) && !cfg_wr
    && !$past(cfg_wr)
    |=> $stable(host_stat_rdata) && $stable(host_stat_upd))
    else $error("status moved while halted");
  a_enable_done: assert property (
    host_cfg_done && !cfg_wr ##1 $stable(host_buf) && !cfg_wr |=> host_enabled)
    else $error("buffer not enabled after configuration");
  cover property (tx_sel);
  cover property (rx_sel ##1 !rx_sel);
  cover property (host_cfg_refused);
endmodule // msgbuf_mgr_chk
bind msgbuf_mgr msgbuf_mgr_chk i_msgbuf_mgr_chk (.*);

// >>> engine_model.sv
// protocol engine model: slot starts, received words and send completions
`timescale 1ns/1ns
module engine_model (
  input  wire logic   mclk,
  output logic        slot_start = 1'b0,
  output logic [10:0] slot_id = '0,
  output logic [7:0]  cycle_num = '0,
  output logic        slot_ch_b = 1'b0,
  output logic        slot_dynamic = 1'b0,
  output logic [15:0] rx_word = '0,
  output logic        rx_word_valid = 1'b0,
  input  wire logic   rx_word_ready,
  output logic        rx_done = 1'b0,
  output logic [7:0]  rx_status = '0,
  output logic        tx_done = 1'b0,
  output logic [7:0]  tx_status = '0,
  output logic [1:0]  tx_pl_addr = '0
);
  int stalls = 0; // ready waits that ran out
  // one-cycle slot pulse; the identity is scrambled after so it never looks current
  task automatic slot(input logic [10:0] id, input logic dyn, input logic ch);
    slot_ch_b = ch;
    slot_id = id;
    slot_dynamic = dyn;
    slot_start = 1'b1;
    @(posedge mclk);
    #1;
    slot_start = 1'b0;
    slot_id = ~id;
  endtask
  // a word or end marker is held until the fifo takes it; valid stays up between words
  task automatic push(input logic [15:0] w, input logic last, input logic [7:0] st);
    int n;
    n = 0;
    rx_word = w;
    rx_word_valid = !last;
    rx_done = last;
    rx_status = st;
    while (!rx_word_ready && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    stalls += int'(!rx_word_ready);
    @(posedge mclk);
    #1;
    if (last) begin
      rx_done = 1'b0;
      rx_word = ~w;
      rx_status = ~st;
    end
  endtask
  // frame sent, status handed back for one cycle
  task automatic sent(input logic [7:0] st);
    tx_done = 1'b1;
    tx_status = st;
    @(posedge mclk);
    #1;
    tx_done = 1'b0;
    tx_status = ~st;
  endtask
endmodule // engine_model

// >>> tb_msgbuf_mgr.sv
// self-checking bench for the message buffer manager
`timescale 1ns/1ns
`include "msgbuf_map.vh"
module tb_msgbuf_mgr;
  logic        mclk = 1'b0, nrst = 1'b0, wp_mode_load = 1'b0, host_c1_wr = 1'b0;
  logic        host_c2_wr = 1'b0, host_cfg_done = 1'b0, host_pl_wr = 1'b0;
  logic        host_valid_set = 1'b0, host_valid_clr = 1'b0, host_lock = 1'b0;
  logic [2:0]  proto_state = '0;
  logic [1:0]  wp_mode_in = '0, host_buf = '0, host_pl_addr = '0;
  logic [21:0] host_c1_wdata = '0;
  logic [19:0] host_c2_wdata = '0;
  logic [15:0] host_pl_wdata = '0;
  wire         host_cfg_refused, host_stat_ch_b, host_stat_upd, host_valid_rdata, host_enabled;
  wire         tx_sel, rx_sel, tx_data_available_flag, tx_preamble, rx_word_ready;
  wire         slot_start, slot_ch_b, slot_dynamic, rx_word_valid, rx_done, tx_done;
  wire [21:0]  host_c1_rdata;
  wire [19:0]  host_c2_rdata;
  wire [15:0]  host_pl_rdata, tx_pl_data, rx_word;
  wire [10:0]  tx_hcrc, slot_id;
  wire [7:0]   host_stat_rdata, rx_status, tx_status, cycle_num;
  wire [6:0]   tx_len;
  wire [1:0]   act_buf, tx_pl_addr;
  logic [31:0] seed = 32'h8DF78F9D; // lfsr state, fixed start
  logic [15:0] exp_w [4];           // words of the last received frame
  logic [7:0]  st;                  // status of the last received frame
  logic [19:0] c2_0;                // class 2 word of buffer 0
  int          num_errors = 0, checks = 0;
  always #2 mclk = ~mclk; // 250 MHz
  msgbuf_mgr i_msgbuf_mgr (.*);
  engine_model i_engine_model (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // class 1 word: type (1 sends), channel A, B too when slot bit 1 is set, every cycle
  function automatic logic [21:0] c1_of(input logic tx, input logic [10:0] slot);
    return {tx, slot[1], 1'b1, slot, 8'hFF};
  endfunction
  // inputs always move one step after the edge so no sampling race is possible
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one configuration write; the refusal pulse stands only in the next cycle
  task automatic wr(input logic [1:0] b, input logic cls2, input logic [21:0] d, input logic rf);
    host_buf = b;
    host_c1_wr = !cls2;
    host_c2_wr = cls2;
    host_c1_wdata = d;
    host_c2_wdata = d[19:0];
    tick(1);
    host_c1_wr = 1'b0;
    host_c2_wr = 1'b0;
    check(host_cfg_refused, rf);
    tick(1);
  endtask
  task automatic look(input logic [1:0] b, input logic v, input logic u, input logic [7:0] s);
    host_buf = b;
    tick(3);
    check(host_valid_rdata, v);
    check(host_stat_upd, u);
    check(host_stat_rdata, s);
    check(host_stat_ch_b, b[1] & u);
  endtask
  task automatic setup(input logic [1:0] b, input logic tx, input logic [10:0] slot);
    seed = lfsr(seed);
    if (b == 2'h0) c2_0 = seed[19:0];
    wr(b, 1'b0, c1_of(tx, slot), 1'b0);
    wr(b, 1'b1, {2'h0, seed[19:0]}, 1'b0);
    host_cfg_done = 1'b1;
    tick(1);
    host_cfg_done = 1'b0;
    tick(2);
    check(host_c1_rdata, c1_of(tx, slot));
    check(host_c2_rdata, seed[19:0]);
    check(host_enabled, 1'b1);
    look(b, 1'b0, 1'b0, 8'h00);
  endtask
  // payload write lands in a transmit buffer and is dropped by a receive buffer
  task automatic pl_rw(input logic [1:0] b, input logic [15:0] d, input logic tx);
    logic [15:0] old;
    host_buf = b;
    host_pl_addr = 2'h1;
    tick(2);
    old = host_pl_rdata;
    host_pl_wdata = tx ? d : ~old;
    host_pl_wr = 1'b1;
    tick(1);
    host_pl_wr = 1'b0;
    tick(2);
    check(host_pl_rdata, tx ? d : old);
  endtask
  task automatic slot_chk(input logic [10:0] id, input logic dyn, input logic tx, input logic [1:0] b);
    i_engine_model.slot(id, dyn, id[1]);
    check(tx_sel, tx);
    check(rx_sel, !tx);
    check(act_buf, b);
  endtask
  task automatic vset;
    host_buf = 2'h2;
    host_valid_set = 1'b1;
    tick(1);
    host_valid_set = 1'b0;
  endtask
  initial begin
    tick(10);
    nrst = 1'b1;
    tick(1);
    check(rx_word_ready, 1'b1);
    wr(2'h0, 1'b0, c1_of(1'b1, 11'h005), 1'b1);
    proto_state = `ST_CONFIG;
    wp_mode_in = `WP_CLASS2;
    wp_mode_load = 1'b1;
    tick(1);
    wp_mode_load = 1'b0;
    for (int b = 0; b < 4; b++)
      setup(b[1:0], !b[0], b < 2 ? 11'h005 : 11'h007);
    pl_rw(2'h0, seed[15:0], 1'b1);
    $display("test configuration done");
    proto_state = `ST_READY;
    tick(1);
    proto_state = `ST_STARTUP;
    tick(1);
    proto_state = `ST_NORM_ACT;
    tick(1);
    i_engine_model.tx_pl_addr = 2'h1;
    slot_chk(11'h005, 1'b0, 1'b1, 2'h0);
    check(tx_pl_data, seed[15:0]);
    check(tx_len, c2_0[`C2_LEN_LO +: `LEN_W]);
    check(tx_preamble, c2_0[`C2_PRE]);
    check(tx_hcrc, c2_0[`C2_HCRC_LO +: `HCRC_W]);
    wr(2'h0, 1'b1, 22'h0, 1'b1);
    i_engine_model.sent(8'h01);
    slot_chk(11'h007, 1'b1, 1'b0, 2'h3);
    host_buf = 2'h3;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      exp_w[i] = seed[15:0];
      i_engine_model.push(seed[15:0], 1'b0, 8'h00);
    end
    st = seed[23:16] | 8'h01;
    i_engine_model.push(16'h0000, 1'b1, st);
    num_errors += i_engine_model.stalls;
    for (int n = 0; n < 10 && host_stat_upd !== 1'b1; n++)
      tick(1);
    if (host_stat_upd !== 1'b1 || i_engine_model.stalls != 0) begin
      num_errors++; // frame never landed
      report_and_stop();
    end
    look(2'h3, 1'b1, 1'b1, st);
    for (int i = 0; i < 4; i++) begin
      host_pl_addr = i[1:0];
      tick(2);
      check(host_pl_rdata, exp_w[i]);
    end
    pl_rw(2'h3, seed[31:16], 1'b0);
    vset();
    slot_chk(11'h007, 1'b1, 1'b1, 2'h2);
    check(tx_data_available_flag, 1'b1);
    i_engine_model.sent(8'h02);
    wr(2'h1, 1'b0, c1_of(1'b1, 11'h009), 1'b1);
    vset();
    look(2'h2, 1'b1, 1'b1, 8'h02);
    host_lock = 1'b1; // buffer 2 is still selected
    tick(1);
    slot_chk(11'h007, 1'b1, 1'b0, 2'h3);
    check(tx_data_available_flag, 1'b0);
    host_lock = 1'b0;
    $display("test slots done");
    proto_state = `ST_READY;
    look(2'h2, 1'b0, 1'b1, 8'h02);
    look(2'h3, 1'b1, 1'b1, st);
    proto_state = `ST_HALT;
    tick(4);
    wr(2'h3, 1'b1, 22'h0, 1'b0);
    tick(2);
    check(host_stat_upd, 1'b0);
    check(host_valid_rdata, 1'b0);
    $display("test state changes done");
    report_and_stop();
  end
endmodule // tb_msgbuf_mgr
